/* File: pkg/pcc_pkg.sv */
/*
 * Constants for the pulse counter command-word block: register map,
 * command-word bit positions, reset values and value formats.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
`default_nettype none
package pcc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CMD     = 8'h00;
	localparam logic [7:0] OFF_DATA_LO = 8'h04;
	localparam logic [7:0] OFF_DATA_HI = 8'h08;
	localparam logic [7:0] OFF_IN_LO   = 8'h0C;
	localparam logic [7:0] OFF_IN_HI   = 8'h10;
	localparam logic [7:0] OFF_STATUS  = 8'h14;
	// Command word bit positions
	localparam int B_LD_SV1    = 0;
	localparam int B_LD_SV2    = 1;
	localparam int B_LD_CNT    = 2;
	localparam int B_HEX       = 3;
	localparam int B_RD_SV1    = 4;
	localparam int B_RD_SV2    = 5;
	localparam int B_RD_CNT    = 6;
	localparam int B_SW_RST    = 7;
	localparam int B_OUT1_EN   = 8;
	localparam int B_OUT2_EN   = 9;
	localparam int B_MODE_LO   = 10;
	localparam int B_RMODE_LO  = 12;
	localparam int B_ERR_KEEP  = 15;
	// Status word bit positions
	localparam int S_COUNTING  = 3;
	localparam int S_HALTED    = 4;
	localparam int S_OUT1      = 5;
	localparam int S_OUT2      = 6;
	// Value format positions inside the 32-bit data pair
	localparam int V_SIGN      = 31;
	localparam int V_COND_LO   = 28;
	// Reset values and bus response codes
	localparam logic [15:0] CMD_RST  = 16'h0000;
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [23:0] VAL_RST  = 24'h000000;
	localparam logic [1:0]  RESP_OK  = 2'h0;
	localparam logic [1:0]  RESP_ERR = 2'h2;
	// Count modes
	typedef enum logic [1:0] {
		CM_NONE,
		CM_PULSE_DIR,
		CM_QUAD_X4,
		CM_QUAD_X1
	} pcc_mode_t;
endpackage
`default_nettype wire

/* File: hw/pcc_counter_ctrl.sv */
/*
 * Incremental pulse counter with command-word control, compare outputs
 * and BCD/hex value exchange over an AXI4-Lite register slave.
 * Assumes encoder, reset and error pins synchronous to CLK_IN (40 MHz).
 */
// Behaviour
// RULE_01 - Set value 1 load edge captures data pair as set value 1.
// RULE_02 - Set value 2 load edge captures data pair as set value 2.
// RULE_03 - Count load edge replaces present count with data pair.
// RULE_04 - Host holds each load bit until its completion flag shows.
// RULE_05 - Coding bit low means BCD, high means hexadecimal, both ways.
// RULE_06 - While set value 1 read bit high, input words show it.
// RULE_07 - While set value 2 read bit high, input words show it.
// RULE_08 - While count read bit high, input words show the count.
// RULE_09 - Internal reset source acts on software bit rising edge only.
// RULE_10 - Output 1 on only when enabled and compare 1 met.
// RULE_11 - Output 2 on only when enabled and compare 2 met.
// RULE_12 - Mode field: 00 keep, 01 pulse-direction, 10 x4, 11 x1.
// RULE_13 - No counting until a mode is set; startup mode counts at once.
// RULE_14 - Mode change while counting clears the count to zero.
// RULE_15 - Reset-source field is mask Z, external, internal; zero keeps.
// RULE_16 - Error with bit low: stop, clear values, outputs off.
// RULE_17 - Error with bit high: counting carries on.
// RULE_18 - One command served: count, sv2, sv1 load, then reads.
// RULE_19 - Condition zero: count >= set value; else count <= set value.
// RULE_20 - Values are signed 24-bit, hex negatives in two's complement.
// RULE_21 - Completion flag clears once host drops its load bit.
// RULE_22 - Zero mode fields leave latched modes unchanged.
`default_nettype none
module pcc_counter_ctrl
	import pcc_pkg::*;
#(
	parameter int AW = 8
) (
	input  wire logic          CLK_IN,
	input  wire logic          RSTN_IN,
	input  wire logic [AW-1:0] S_AXI_AWADDR_IN,
	input  wire logic          S_AXI_AWVALID_IN,
	output logic               S_AXI_AWREADY_OUT,
	input  wire logic [31:0]   S_AXI_WDATA_IN,
	input  wire logic [3:0]    S_AXI_WSTRB_IN,
	input  wire logic          S_AXI_WVALID_IN,
	output logic               S_AXI_WREADY_OUT,
	output logic [1:0]         S_AXI_BRESP_OUT,
	output logic               S_AXI_BVALID_OUT,
	input  wire logic          S_AXI_BREADY_IN,
	input  wire logic [AW-1:0] S_AXI_ARADDR_IN,
	input  wire logic          S_AXI_ARVALID_IN,
	output logic               S_AXI_ARREADY_OUT,
	output logic [31:0]        S_AXI_RDATA_OUT,
	output logic [1:0]         S_AXI_RRESP_OUT,
	output logic               S_AXI_RVALID_OUT,
	input  wire logic          S_AXI_RREADY_IN,
	input  wire logic          ENC_A_IN,
	input  wire logic          ENC_B_IN,
	input  wire logic          ENC_Z_IN,
	input  wire logic          EXT_RST_IN,
	input  wire logic          IO_ERR_IN,
	input  wire logic [1:0]    MODE_STRAP_IN,
	output logic               OUT1_OUT,
	output logic               OUT2_OUT
);

	// Signed 24-bit value from a data pair in the selected coding
	function automatic logic [23:0] to_bin(input logic [31:0] w,
			input logic hex);
		logic [31:0] mag;
		mag = 32'h0;
		for (int i = 6; i >= 0; i--) begin
			mag = mag * 32'd10 + {28'h0, w[i*4 +: 4]};
		end
		if (hex)
			to_bin = w[23:0];
		else if (w[V_SIGN])
			to_bin = 24'(-mag);
		else
			to_bin = mag[23:0];
	endfunction

	// Seven BCD digits of a magnitude, by shift-and-add-three
	function automatic logic [27:0] to_bcd(input logic [23:0] mag);
		logic [27:0] bcd;
		bcd = 28'h0;
		for (int i = 23; i >= 0; i--) begin
			for (int d = 0; d < 7; d++) begin
				if (bcd[d*4 +: 4] > 4'h4)
					bcd[d*4 +: 4] = bcd[d*4 +: 4] + 4'h3;
			end
			bcd = {bcd[26:0], mag[i]};
		end
		to_bcd = bcd;
	endfunction

	// Read-back pair: condition in the top nibble, with the sign there in BCD only
	function automatic logic [31:0] to_word(input logic [23:0] v,
			input logic [2:0] cond, input logic hex);
		logic [23:0] mag;
		mag = v[23] ? 24'(-v) : v;
		if (hex)
			to_word = {1'b0, cond, 4'h0, v};
		else
			to_word = {v[23], cond, to_bcd(mag)};
	endfunction

	function automatic pcc_mode_t dec_mode(input logic [1:0] f);
		unique case (f)
			2'h0: dec_mode = CM_NONE;
			2'h1: dec_mode = CM_PULSE_DIR;
			2'h2: dec_mode = CM_QUAD_X4;
			2'h3: dec_mode = CM_QUAD_X1;
		endcase
	endfunction

	logic [15:0] cmd_q, cmd_d, lo_q, lo_d, hi_q, hi_d;
	logic [15:0] in_lo_q, in_lo_d, in_hi_q, in_hi_d;
	logic [23:0] cnt_q, cnt_d, sv1_q, sv1_d, sv2_q, sv2_d;
	logic [2:0]  c1_q, c1_d, c2_q, c2_d, rmask_q, rmask_d, done_q, done_d;
	pcc_mode_t   mode_q, mode_d;
	logic        started_q, started_d, halt_q, halt_d;
	logic        a_q, b_q, z_q, e_q, sw_q, o1_q, o1_d, o2_q, o2_d;
	logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [AW-1:0] waddr_q, waddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0]  wstrb_q, wstrb_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic        wr_fire;
	logic [31:0] status;

	assign S_AXI_AWREADY_OUT = !aw_have_q && !bvalid_q;
	assign S_AXI_WREADY_OUT  = !w_have_q && !bvalid_q;
	assign S_AXI_ARREADY_OUT = !rvalid_q;
	assign S_AXI_BVALID_OUT  = bvalid_q;
	assign S_AXI_BRESP_OUT   = bresp_q;
	assign S_AXI_RVALID_OUT  = rvalid_q;
	assign S_AXI_RDATA_OUT   = rdata_q;
	assign S_AXI_RRESP_OUT   = rresp_q;
	assign OUT1_OUT          = o1_q;
	assign OUT2_OUT          = o2_q;
	// Write lands once both halves are held; keeps the two orders equal
	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
	assign status  = {25'h0, o2_q, o1_q, halt_q,
		started_q && mode_q != CM_NONE && !halt_q, done_q};

	// Bus channel handshakes and read mux
	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d  = w_have_q;
		waddr_d   = waddr_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
			aw_have_d = 1'b1;
			waddr_d   = S_AXI_AWADDR_IN;
		end
		if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
			w_have_d = 1'b1;
			wdata_d  = S_AXI_WDATA_IN;
			wstrb_d  = S_AXI_WSTRB_IN;
		end
		if (wr_fire) begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = (waddr_q[7:0] <= OFF_STATUS && waddr_q[1:0] == 2'h0)
				? RESP_OK : RESP_ERR;
		end else if (bvalid_q && S_AXI_BREADY_IN) begin
			bvalid_d = 1'b0;
		end
		if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
			rvalid_d = 1'b1;
			rresp_d  = RESP_OK;
			unique case (S_AXI_ARADDR_IN[7:0])
				OFF_CMD:     rdata_d = 32'h0; // Command word is write-only
				OFF_DATA_LO: rdata_d = {16'h0, lo_q};
				OFF_DATA_HI: rdata_d = {16'h0, hi_q};
				OFF_IN_LO:   rdata_d = {16'h0, in_lo_q};
				OFF_IN_HI:   rdata_d = {16'h0, in_hi_q};
				OFF_STATUS:  rdata_d = status;
				default: begin
					rdata_d = 32'h0;
					rresp_d = RESP_ERR;
				end
			endcase
		end else if (rvalid_q && S_AXI_RREADY_IN) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			waddr_q   <= '0;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OK;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0;
			rresp_q   <= RESP_OK;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			waddr_q   <= waddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

	// Counter, command decode, compare outputs; later steps override
	always_comb begin
		logic [15:0] c;
		logic [31:0] dw;
		logic [2:0]  pend;
		logic        step, up, hex, cmp1, cmp2;
		pcc_mode_t   nm;
		c        = cmd_q;
		dw       = {hi_q, lo_q};
		hex      = cmd_q[B_HEX];
		pend     = cmd_q[2:0] & ~done_q;
		step     = 1'b0;
		up       = 1'b1;
		nm       = CM_NONE;
		cmp1     = 1'b0;
		cmp2     = 1'b0;
		lo_d     = lo_q;
		hi_d     = hi_q;
		if (wr_fire && waddr_q[7:0] == OFF_CMD)
			for (int i = 0; i < 2; i++)
				if (wstrb_q[i]) c[i*8 +: 8] = wdata_q[i*8 +: 8];
		if (wr_fire && waddr_q[7:0] == OFF_DATA_LO)
			for (int i = 0; i < 2; i++)
				if (wstrb_q[i]) lo_d[i*8 +: 8] = wdata_q[i*8 +: 8];
		if (wr_fire && waddr_q[7:0] == OFF_DATA_HI)
			for (int i = 0; i < 2; i++)
				if (wstrb_q[i]) hi_d[i*8 +: 8] = wdata_q[i*8 +: 8];
		cmd_d     = c;
		started_d = 1'b1;
		halt_d    = halt_q;
		cnt_d     = cnt_q;
		sv1_d     = sv1_q;
		sv2_d     = sv2_q;
		c1_d      = c1_q;
		c2_d      = c2_q;
		in_lo_d   = in_lo_q;
		in_hi_d   = in_hi_q;
		rmask_d   = rmask_q;
		mode_d    = mode_q;
		// Strap seen first cycle after release, then the command word
		nm = started_q ? dec_mode(cmd_q[B_MODE_LO +: 2])
			: dec_mode(MODE_STRAP_IN); // [RULE_13]
		if (nm != CM_NONE)
			mode_d = nm; // [RULE_12] [RULE_22]
		if (cmd_q[B_RMODE_LO +: 3] != 3'h0)
			rmask_d = cmd_q[B_RMODE_LO +: 3]; // [RULE_15] [RULE_22]
		// x4 direction from current A against previous B; pulse-direction and x1 from current B
		unique case (mode_q)
			CM_NONE: ;
			CM_PULSE_DIR, CM_QUAD_X1: begin
				step = ENC_A_IN && !a_q;
				up   = !ENC_B_IN;
			end
			CM_QUAD_X4: begin
				step = (ENC_A_IN ^ a_q) ^ (ENC_B_IN ^ b_q);
				up   = ENC_A_IN ^ b_q;
			end
		endcase
		if (step && !halt_q) // [RULE_13] [RULE_17]
			cnt_d = up ? cnt_q + 24'h1 : cnt_q - 24'h1;
		if ((rmask_q[0] && ENC_Z_IN && !z_q)
				|| (rmask_q[1] && EXT_RST_IN && !e_q)
				|| (rmask_q[2] && cmd_q[B_SW_RST] && !sw_q))
			cnt_d = VAL_RST; // [RULE_09]
		if (mode_q != CM_NONE && mode_d != mode_q)
			cnt_d = VAL_RST; // [RULE_14]
		// A flag drops with its bit; the host holds the bit until set
		done_d = done_q & cmd_q[2:0]; // [RULE_21] [RULE_04]
		if (pend[B_LD_CNT]) begin // [RULE_18]
			cnt_d          = to_bin(dw, hex); // [RULE_03] [RULE_05] [RULE_20]
			done_d[B_LD_CNT] = 1'b1;
		end else if (pend[B_LD_SV2]) begin
			sv2_d          = to_bin(dw, hex); // [RULE_02] [RULE_20]
			c2_d           = dw[V_COND_LO +: 3];
			done_d[B_LD_SV2] = 1'b1;
		end else if (pend[B_LD_SV1]) begin
			sv1_d          = to_bin(dw, hex); // [RULE_01] [RULE_20]
			c1_d           = dw[V_COND_LO +: 3];
			done_d[B_LD_SV1] = 1'b1;
		end else if (cmd_q[B_RD_CNT]) begin
			{in_hi_d, in_lo_d} = to_word(cnt_q, 3'h0, hex); // [RULE_08]
			if (hex)
				in_hi_d = {8'h00, cnt_q[23:16]};
		end else if (cmd_q[B_RD_SV2]) begin
			{in_hi_d, in_lo_d} = to_word(sv2_q, c2_q, hex); // [RULE_07]
		end else if (cmd_q[B_RD_SV1]) begin
			{in_hi_d, in_lo_d} = to_word(sv1_q, c1_q, hex); // [RULE_06]
		end
		// Sticky until reset: the unit must be restarted after the error
		if (IO_ERR_IN && !cmd_q[B_ERR_KEEP])
			halt_d = 1'b1;
		if (halt_d) begin // [RULE_16]
			cnt_d = VAL_RST;
			sv1_d = VAL_RST;
			sv2_d = VAL_RST;
		end
		cmp1 = (c1_q == 3'h0) ? $signed(cnt_q) >= $signed(sv1_q)
			: $signed(cnt_q) <= $signed(sv1_q); // [RULE_19]
		cmp2 = (c2_q == 3'h0) ? $signed(cnt_q) >= $signed(sv2_q)
			: $signed(cnt_q) <= $signed(sv2_q);
		o1_d = cmd_q[B_OUT1_EN] && cmp1 && !halt_d; // [RULE_10] [RULE_16]
		o2_d = cmd_q[B_OUT2_EN] && cmp2 && !halt_d; // [RULE_11]
	end

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			cmd_q     <= CMD_RST;
			lo_q      <= DATA_RST;
			hi_q      <= DATA_RST;
			in_lo_q   <= DATA_RST;
			in_hi_q   <= DATA_RST;
			cnt_q     <= VAL_RST;
			sv1_q     <= VAL_RST;
			sv2_q     <= VAL_RST;
			c1_q      <= 3'h0;
			c2_q      <= 3'h0;
			rmask_q   <= 3'h0;
			done_q    <= 3'h0;
			mode_q    <= CM_NONE;
			started_q <= 1'b0;
			halt_q    <= 1'b0;
			{a_q, b_q, z_q, e_q, sw_q} <= 5'h00;
			o1_q      <= 1'b0;
			o2_q      <= 1'b0;
		end else begin
			cmd_q     <= cmd_d;
			lo_q      <= lo_d;
			hi_q      <= hi_d;
			in_lo_q   <= in_lo_d;
			in_hi_q   <= in_hi_d;
			cnt_q     <= cnt_d;
			sv1_q     <= sv1_d;
			sv2_q     <= sv2_d;
			c1_q      <= c1_d;
			c2_q      <= c2_d;
			rmask_q   <= rmask_d;
			done_q    <= done_d;
			mode_q    <= mode_d;
			started_q <= started_d;
			halt_q    <= halt_d;
			{a_q, b_q, z_q, e_q, sw_q} <=
				{ENC_A_IN, ENC_B_IN, ENC_Z_IN, EXT_RST_IN, cmd_q[B_SW_RST]};
			o1_q      <= o1_d;
			o2_q      <= o2_d;
		end
	end

endmodule
`default_nettype wire

/* File: tb/pcc_field_model.sv */
/*
 * Field-side encoder model giving pulse and direction phases.
 * Assumes one-cycle step requests in the bench clock domain.
 */
`default_nettype none
module pcc_field_model (
	input  wire logic clk_in,
	input  wire logic step_in,
	input  wire logic down_in,
	output logic      enc_a_out,
	output logic      enc_b_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// Direction lands with the A rise; no phase skew is modelled
	always @(posedge clk_in) begin
		enc_a_out <= step_in;
		enc_b_out <= down_in;
	end
endmodule
`default_nettype wire

/* File: tb/pcc_counter_ctrl_checker.sv */
/*
 * Handshake and wake-up assertions for the pulse counter block.
 * Assumes it is bound to pcc_counter_ctrl with sync active-low reset.
 */
`default_nettype none
module pcc_counter_ctrl_checker (
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	input wire logic S_AXI_AWVALID_IN,
	input wire logic S_AXI_AWREADY_OUT,
	input wire logic S_AXI_WVALID_IN,
	input wire logic S_AXI_WREADY_OUT,
	input wire logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	input wire logic S_AXI_ARVALID_IN,
	input wire logic S_AXI_ARREADY_OUT,
	input wire logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	input wire logic OUT1_OUT,
	input wire logic OUT2_OUT
);
	default clocking @(posedge CLK_IN);
	endclocking
	default disable iff (!RSTN_IN);
	// Address and data taken together at one edge
	sequence s_wr_take;
		S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT &&
		S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
	endsequence
	sequence s_rd_take;
		S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
	endsequence
	// Bus answers are bounded so a stuck slave shows up
	a_wr_answer: assert property (s_wr_take |-> ##[1:2] S_AXI_BVALID_OUT)
		else $error("write response missing");
	a_rd_answer: assert property (s_rd_take |=> S_AXI_RVALID_OUT)
		else $error("read data late");
	a_b_hold: assert property (
		S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT)
		else $error("write response dropped");
	a_r_hold: assert property (
		S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT)
		else $error("read data dropped");
	a_b_blocks_wr: assert property (S_AXI_BVALID_OUT |->
		!S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT)
		else $error("write taken during response");
	a_r_blocks_rd: assert property (S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT)
		else $error("read taken during data");
	a_b_once: assert property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN
		|=> !S_AXI_BVALID_OUT)
		else $error("write response repeated");
	a_wake_quiet: assert property ($rose(RSTN_IN) |->
		!OUT1_OUT && !OUT2_OUT && !S_AXI_RVALID_OUT)
		else $error("outputs active after reset");
endmodule
bind pcc_counter_ctrl pcc_counter_ctrl_checker u_pcc_counter_ctrl_checker (
	.CLK_IN, .RSTN_IN, .S_AXI_AWVALID_IN, .S_AXI_AWREADY_OUT,
	.S_AXI_WVALID_IN, .S_AXI_WREADY_OUT, .S_AXI_BVALID_OUT,
	.S_AXI_BREADY_IN, .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT,
	.S_AXI_RVALID_OUT, .S_AXI_RREADY_IN, .OUT1_OUT, .OUT2_OUT
);
`default_nettype wire

/* File: tb/tb_top.sv */
/*
 * Self-checking bench for the pulse counter block over AXI4-Lite.
 * Assumes package, field model and checker are compiled first.
 */
`default_nettype none
module tb_top
	import pcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [15:0] HX = 16'h0008; // Hex coding select
	logic        clk, rstn, awv, wv, br, arv, rr, step, dn, err, ez, ex;
	logic        awr, wrd, bv, arr, rv, o1, o2, ea, eb;
	logic [7:0]  awa, ara;
	logic [31:0] wda, rdt, v;
	logic [1:0]  bre, rre, brsp, rrsp, strap;
	int          mismatches, num_checks, cyc;
	// Strobes always full: only the two low lanes carry register data
	pcc_counter_ctrl u_pcc_counter_ctrl (
		.CLK_IN(clk), .RSTN_IN(rstn), .S_AXI_AWADDR_IN(awa),
		.S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
		.S_AXI_WDATA_IN(wda), .S_AXI_WSTRB_IN(4'hF),
		.S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrd),
		.S_AXI_BRESP_OUT(bre), .S_AXI_BVALID_OUT(bv),
		.S_AXI_BREADY_IN(br), .S_AXI_ARADDR_IN(ara),
		.S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
		.S_AXI_RDATA_OUT(rdt), .S_AXI_RRESP_OUT(rre),
		.S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr),
		.ENC_A_IN(ea), .ENC_B_IN(eb), .ENC_Z_IN(ez),
		.EXT_RST_IN(ex), .IO_ERR_IN(err), .MODE_STRAP_IN(strap),
		.OUT1_OUT(o1), .OUT2_OUT(o2));
	pcc_field_model u_pcc_field_model (.clk_in(clk), .step_in(step),
		.down_in(dn), .enc_a_out(ea), .enc_b_out(eb));
	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Hang guard far above the few hundred cycles needed
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			results();
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Readies sampled mid-cycle, where combinational paths have settled
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic ta, tw, tb;
		awa <= a;
		wda <= {16'h0000, d};
		{awv, wv, br} <= 3'b111;
		do begin
			@(negedge clk);
			{ta, tw, tb, brsp} = {awv & awr, wv & wrd, bv, bre};
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end while (!tb);
		br <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		logic ta, tr;
		ara <= a;
		{arv, rr} <= 2'b11;
		do begin
			@(negedge clk);
			{ta, tr, v, rrsp} = {arv & arr, rv, rdt, rre};
			@(posedge clk);
			if (ta) arv <= 1'b0;
		end while (!tr);
		rr <= 1'b0;
		@(posedge clk);
	endtask
	// Load bit stays up until its flag shows, then drops
	task automatic ld(input logic [15:0] c, input int b,
		input logic [15:0] hi, lo);
		wr(OFF_DATA_HI, hi);
		wr(OFF_DATA_LO, lo);
		wr(OFF_CMD, c | (16'h0001 << b));
		do rd(OFF_STATUS); while (v[b] !== 1'b1);
		wr(OFF_CMD, c);
		do rd(OFF_STATUS); while (v[b] !== 1'b0);
	endtask
	task automatic cr(input logic [15:0] c, input logic [31:0] e);
		logic [31:0] lo;
		wr(OFF_CMD, c);
		rd(OFF_IN_LO);
		lo = v;
		rd(OFF_IN_HI);
		chk("in_words", {v[15:0], lo[15:0]}, e);
	endtask
	task automatic pulse(input int n, input logic d);
		repeat (n) begin
			step <= 1'b1;
			dn <= d;
			@(posedge clk);
			step <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask
	// One gray cycle per turn, A leading B: four x4 counts upward
	task automatic quad(input int n);
		logic [7:0] seq = 8'hB4;
		repeat (n) begin
			for (int i = 3; i >= 0; i--) begin
				{step, dn} <= seq[i*2 +: 2];
				@(posedge clk);
			end
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Reset, then walk loads, reads, outputs, modes and error handling
	initial begin
		{rstn, awv, wv, br, arv, rr, step, dn, err, ez, ex} = '0;
		{awa, ara, wda, strap} = '0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(OFF_STATUS);
		chk("status", v, 32'h0);
		pulse(1, 1'b0);
		cr(16'h0040, 32'h0000_0000);
		rd(8'h18);
		chk("rresp", 32'(rrsp), 32'(RESP_ERR));
		wr(8'h18, 16'h0001);
		chk("bresp", 32'(brsp), 32'(RESP_ERR));
		ld(16'h0000, 2, 16'h8000, 16'h1234);
		cr(HX | 16'h0040, 32'h00FF_FB2E);
		cr(16'h0040, 32'h8000_1234);
		ld(HX, 2, 16'h0000, 16'h0007);
		ld(HX, 0, 16'h0000, 16'h0005);
		ld(HX, 1, 16'h1000, 16'h0009);
		cr(HX | 16'h0070, 32'h0000_0007);
		cr(HX | 16'h0030, 32'h1000_0009);
		cr(HX | 16'h0310, 32'h0000_0005);
		chk("out1", 32'(o1), 32'h1);
		chk("out2", 32'(o2), 32'h1);
		ld(HX | 16'h0200, 2, 16'h0000, 16'h000A);
		chk("out1", 32'(o1), 32'h0);
		chk("out2", 32'(o2), 32'h0);
		ld(HX | 16'h0400, 2, 16'h0000, 16'h0010);
		wr(OFF_CMD, HX);
		pulse(3, 1'b0);
		pulse(1, 1'b1);
		cr(HX | 16'h0040, 32'h0000_0012);
		cr(HX | 16'h4C40, 32'h0000_0000);
		pulse(2, 1'b0);
		cr(HX | 16'h0040, 32'h0000_0002);
		cr(HX | 16'h00C0, 32'h0000_0000);
		pulse(1, 1'b0);
		cr(HX | 16'h00C0, 32'h0000_0001);
		cr(HX | 16'h0840, 32'h0000_0000);
		quad(1);
		cr(HX | 16'h0040, 32'h0000_0004);
		cr(HX | 16'h8C40, 32'h0000_0000);
		err <= 1'b1;
		pulse(1, 1'b0);
		cr(HX | 16'h8040, 32'h0000_0001);
		cr(HX | 16'h0240, 32'h0000_0000);
		rd(OFF_STATUS);
		chk("halted", 32'(v[S_HALTED]), 32'h1);
		chk("out2", 32'(o2), 32'h0);
		cr(HX | 16'h0010, 32'h0000_0000);
		// Second start with a strapped mode: counting begins unasked
		rstn <= 1'b0;
		err <= 1'b0;
		strap <= 2'b01;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(OFF_STATUS);
		chk("status", v, 32'h0000_0008);
		pulse(2, 1'b0);
		cr(HX | 16'h1040, 32'h0000_0002);
		ez <= 1'b1;
		@(posedge clk);
		ez <= 1'b0;
		cr(HX | 16'h2040, 32'h0000_0000);
		pulse(1, 1'b0);
		ez <= 1'b1;
		@(posedge clk);
		ez <= 1'b0;
		cr(HX | 16'h0040, 32'h0000_0001);
		ex <= 1'b1;
		@(posedge clk);
		ex <= 1'b0;
		cr(HX | 16'h0040, 32'h0000_0000);
		results();
	end
endmodule
`default_nettype wire
